// ==== dv/tb_wdr_watchdog.sv ====
`timescale 1ns/1ps
`include "wdr_consts.vh"
module tb_wdr_watchdog;
  logic clk = 0, rst_n = 0, ce = 1, slow = 0, lows = 0, clr = 0, halt = 0, wake = 0;
  logic psel = 0, pen = 0, pwr = 0, rdy, err, sysr, pcsp, tmo, pdn, lpm;
  logic [11:0] addr = 0;
  logic [31:0] wd = 0, rd, r;
  logic e, slow_run = 0, sysr_q = 0;
  int n_fail = 0, n_compared = 0, n_rst = 0, n_pc = 0, cyc = 0, t0, sdiv = 0;
  always #2.5 clk = ~clk;
  wdr_watchdog #(.SOFT_DELAY(2)) u_dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_ce(ce),
    .i_slow_clk(slow), .i_low_supply(lows), .i_clear_watchdog_instruction(clr), .i_halt(halt), .i_wake(wake),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd),
    .o_pready(rdy), .o_prdata(rd), .o_pslverr(err), .o_sys_reset(sysr), .o_pc_sp_clear(pcsp),
    .o_timeout(tmo), .o_power_down(pdn), .o_low_power_mode(lpm));
  // slow oscillator only runs when a scenario wants ticks; one tick per 8 ref cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sysr_q <= sysr;
    if (sysr && !sysr_q) n_rst <= n_rst + 1;
    if (pcsp) n_pc <= n_pc + 1;
    if (slow_run) begin
      sdiv <= (sdiv == 3) ? 0 : sdiv + 1;
      if (sdiv == 3) slow <= ~slow;
    end
  end
  task chk(input string n, input [31:0] x, input [31:0] g);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task apb(input logic w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1; pwr <= w; addr <= a; wd <= d; pen <= 0;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    r = rd;
    e = err;
    psel <= 0; pen <= 0;
  endtask
  // k selects the event: 0 clear-watchdog, 1 halt, other wake
  task pulse(input int k);
    @(posedge clk);
    if (k == 0) clr <= 1;
    else if (k == 1) halt <= 1;
    else wake <= 1;
    @(posedge clk);
    clr <= 0;
    halt <= 0;
    wake <= 0;
    repeat (3) @(posedge clk);
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #150us;
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    apb(0, `WDR_ADDR_STATUS, 0); chk("status por", 0, r & 32'h3);
    apb(0, `WDR_ADDR_WDOG_CTRL, 0); chk("ctrl por", 32'h53, r);
    apb(0, `WDR_ADDR_RST_FLAGS, 0); chk("flags unused", 0, r & 32'hfffffffa);
    for (int p = 0; p < 8; p++) begin
      apb(1, `WDR_ADDR_WDOG_CTRL, 32'h50 | p);
      apb(0, `WDR_ADDR_WDOG_CTRL, 0); chk("ctrl rw", 32'h50 | p, r);
    end
    apb(0, 12'h020, 0); chk("unmapped err", 1, e);
    apb(1, `WDR_ADDR_WDOG_CTRL, 32'ha8);
    slow_run <= 1;
    // 200 ticks between clears stays below the 2^8 limit
    repeat (3) begin
      repeat (1600) @(posedge clk);
      pulse(0);
    end
    chk("clear holds off", 0, n_rst);
    apb(1, `WDR_ADDR_WDOG_CTRL, 32'haf);
    repeat (2400) @(posedge clk);
    t0 = cyc;
    apb(1, `WDR_ADDR_WDOG_CTRL, 32'ha8);
    wait (n_rst == 1);
    slow_run <= 0;
    chk("select at once", 1, (cyc - t0) <= 40);
    apb(0, `WDR_ADDR_STATUS, 0); chk("run timeout", 1, r & 32'h3);
    apb(1, `WDR_ADDR_WDOG_CTRL, 32'ha8);
    pulse(1); chk("halt flags", 3'b110, {lpm, pdn, tmo});
    t0 = cyc;
    slow_run <= 1;
    wait (n_pc == 1);
    slow_run <= 0;
    chk("overflow late", 1, (cyc - t0) >= 250 * 8);
    chk("overflow early", 1, (cyc - t0) <= 262 * 8);
    repeat (3) @(posedge clk);
    chk("sleep flags", 3'b011, {lpm, pdn, tmo});
    chk("sleep no reset", 1, n_rst);
    pulse(0); chk("clr pdown", 0, pdn);
    pulse(1);
    lows <= 1; repeat (300) @(posedge clk); lows <= 0;
    repeat (10) @(posedge clk); chk("lv off in sleep", 1, n_rst);
    pulse(2); chk("wake", 0, lpm);
    lows <= 1; repeat (100) @(posedge clk); lows <= 0;
    repeat (10) @(posedge clk); chk("short low", 1, n_rst);
    lows <= 1; repeat (300) @(posedge clk); lows <= 0;
    chk("long low", 2, n_rst);
    apb(0, `WDR_ADDR_RST_FLAGS, 0); chk("lv flag", 32'h4, r);
    apb(1, `WDR_ADDR_RST_FLAGS, 0);
    apb(0, `WDR_ADDR_RST_FLAGS, 0); chk("lv clear", 0, r);
    apb(1, `WDR_ADDR_WDOG_CTRL, 32'h00);
    slow_run <= 1;
    wait (n_rst == 3);
    slow_run <= 0;
    repeat (8) @(posedge clk);
    apb(0, `WDR_ADDR_RST_FLAGS, 0); chk("soft flag", 32'h1, r);
    apb(0, `WDR_ADDR_WDOG_CTRL, 0); chk("ctrl restored", 32'h53, r);
    apb(1, `WDR_ADDR_RST_FLAGS, 0);
    apb(0, `WDR_ADDR_RST_FLAGS, 0); chk("soft clear", 0, r);
    apb(1, `WDR_ADDR_PROG_CTRL, 32'h55);
    repeat (4) @(posedge clk); chk("prog reset", 4, n_rst);
    repeat (10) @(posedge clk);
    report_and_stop;
  end
endmodule

// ==== dv/wdr_watchdog_chk.sv ====
`timescale 1ns/1ps
module wdr_watchdog_chk (
  input wire i_ref_clk, // clock
  input wire i_reset_n, // async reset, active low
  input wire i_ce, // clock enable
  input wire i_halt, // halt pulse
  input wire i_clear_watchdog_instruction, // clear pulse
  input wire i_psel, // apb select
  input wire i_penable, // apb enable
  input wire i_pwrite, // apb write
  input wire [11:0] i_paddr, // apb address
  input wire [31:0] i_pwdata, // apb write data
  input wire [31:0] o_prdata, // apb read data
  input wire o_sys_reset, // full reset
  input wire o_pc_sp_clear, // pc and sp clear
  input wire o_timeout, // timeout bit
  input wire o_power_down, // power-down flag
  input wire o_low_power_mode // sleep or idle
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  wire acc = i_psel && i_penable && i_ce;
  halt_flags_a: assert property (i_ce && i_halt |=> o_power_down && !o_timeout && o_low_power_mode)
    else $error("halt did not set the power flags");
  clr_pdown_a: assert property (i_ce && i_clear_watchdog_instruction && !i_halt |=> !o_power_down)
    else $error("clear did not drop power-down");
  prog_key_a: assert property (acc && i_pwrite && i_paddr == 12'h008 && i_pwdata[7:0] == 8'h55
    |-> ##[1:2] o_sys_reset)
    else $error("programming key gave no reset");
  rst_len_a: assert property ($rose(o_sys_reset) |-> o_sys_reset[*4] ##1 !o_sys_reset)
    else $error("reset pulse length wrong");
  pcsp_pulse_a: assert property (o_pc_sp_clear |-> !o_sys_reset ##1 !o_pc_sp_clear)
    else $error("pc clear not a lone pulse");
  pcsp_flags_a: assert property (o_pc_sp_clear |=> o_timeout && o_power_down && !o_low_power_mode)
    else $error("flags wrong after sleep timeout");
  flag_zero_a: assert property (i_ce && i_psel && !i_penable && i_paddr == 12'h004
    |=> o_prdata[7:3] == 5'h00 && !o_prdata[1])
    else $error("reserved flag bits not zero");
  timeout_clr_a: assert property ($fell(o_timeout) |-> $past(i_halt))
    else $error("timeout dropped without halt");
  pdown_set_a: assert property ($rose(o_power_down) |-> $past(i_halt))
    else $error("power-down rose without halt");
endmodule
bind wdr_watchdog wdr_watchdog_chk u_chk (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
  .i_ce(i_ce), .i_halt(i_halt), .i_clear_watchdog_instruction(i_clear_watchdog_instruction), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_sys_reset(o_sys_reset), .o_pc_sp_clear(o_pc_sp_clear), .o_timeout(o_timeout),
  .o_power_down(o_power_down), .o_low_power_mode(o_low_power_mode));

// ==== pkg/wdr_consts.vh ====
`ifndef WDR_CONSTS_VH
`define WDR_CONSTS_VH
// register byte addresses on the bus
`define WDR_ADDR_WDOG_CTRL 12'h000
`define WDR_ADDR_RST_FLAGS 12'h004
`define WDR_ADDR_PROG_CTRL 12'h008
`define WDR_ADDR_STATUS 12'h00c
`define WDR_ADDR_CONTROL 12'h010
// watchdog_control layout
`define WDR_WDOG_CTRL_RESET 8'h53
`define WDR_EN_HI 7
`define WDR_EN_LO 3
`define WDR_PS_HI 2
`define WDR_PS_LO 0
`define WDR_EN_LEGAL_A 5'h0a
`define WDR_EN_LEGAL_B 5'h15
// reset_source_flags layout
`define WDR_BIT_SOFT_FLAG 0
`define WDR_BIT_LV_FLAG 2
// status register layout
`define WDR_BIT_TIMEOUT 0
`define WDR_BIT_PDOWN 1
`define WDR_BIT_LOWPWR 2
// control register layout (bits not decoded; writes ignored, reads zero)
`define WDR_BIT_CLRWDT 0
`define WDR_BIT_HALT 1
`define WDR_BIT_WAKE 2
// programming control trigger value
`define WDR_PROG_RESET_KEY 8'h55
// counter
`define WDR_CNT_W 18
// last count before overflow for each period select code
`define WDR_LIMIT_SEL0 18'h000ff
`define WDR_LIMIT_SEL1 18'h003ff
`define WDR_LIMIT_SEL2 18'h00fff
`define WDR_LIMIT_SEL3 18'h03fff
`define WDR_LIMIT_SEL4 18'h07fff
`define WDR_LIMIT_SEL5 18'h0ffff
`define WDR_LIMIT_SEL6 18'h1ffff
`define WDR_LIMIT_SEL7 18'h3ffff
`define WDR_SOFT_DELAY_DEF 8
`define WDR_LV_QUALIFY_NS 1000
`define WDR_CLK_PERIOD_NS 5
`define WDR_RST_PULSE 3'h4
`endif

// ==== rtl/wdr_pulse_sync.v ====
`timescale 1ns/1ps
// two-flop synchroniser plus rising edge detect on the second stage
module wdr_pulse_sync (
  input wire i_ref_clk, // system clock
  input wire i_reset_n, // async reset, active low
  input wire i_ce, // clock enable
  input wire i_async, // level from another domain
  output wire o_level, // synchronised level
  output wire o_rise // one-cycle pulse on rising edge
);
  reg meta;
  reg sync;
  reg prev;
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else if (i_ce) begin
      meta <= i_async;
      sync <= meta;
      prev <= sync;
    end
  end
  assign o_level = sync;
  assign o_rise = i_ce & sync & ~prev;
endmodule

// ==== rtl/wdr_watchdog.v ====
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Function
// RULE1 - watchdog counts slow-clock ticks, timeout 2^8 up to 2^18 ticks
// RULE2 - period select codes map to 2^8,10,12,14,15,16,17,18
// RULE3 - guarded enable field legal only at 01010 or 10101
// RULE4 - any other enable value gives delayed full reset and sets soft flag
// RULE5 - guarded enable field powers up as 01010
// RULE6 - control register read/write, enable bits 7..3, period bits 2..0
// RULE7 - soft reset flag in bit 0, set by hardware, cleared only by software
// RULE8 - overflow in run mode gives full reset and sets timeout bit
// RULE9 - overflow in sleep/idle sets timeout, clears only pc and stack pointer
// RULE10 - counter cleared by guarded-field reset, clear instruction or halt only; code also clears it on overflow
// RULE11 - software must clear the watchdog before the timeout is reached
// RULE12 - power-on reset leaves program counter at zero
// RULE13 - power-on reset sets port data and direction registers to all ones
// RULE14 - low supply resets and sets flag only if it lasts the qualify time
// RULE15 - low-voltage detection active in run modes, off in sleep or idle
// RULE16 - low-voltage flag in bit 2, set by hardware, cleared only by software
// RULE17 - reset flag register bits 7..3 and bit 1 read as zero
// RULE18 - writing 55h to programming control register resets whole device
// RULE19 - halt sets power-down, clears timeout, clears and restarts counter
// RULE20 - power-down flag cleared at power-up and by clear instruction
// RULE21 - por clears both flags; run timeout sets timeout only; sleep keeps both (code sets timeout on a sleep timeout, keeps power-down)
// RULE22 - soft reset delay is a parameter counted in slow-clock ticks
// RULE23 - counter runs in every mode; period change needs no counter clear
`include "wdr_consts.vh"
module wdr_watchdog #(
  parameter SOFT_DELAY = `WDR_SOFT_DELAY_DEF // slow ticks before soft reset
) (
  input wire i_ref_clk, // 200 MHz system clock
  input wire i_reset_n, // power-on reset, async, active low
  input wire i_ce, // clock enable, freezes all state when low
  input wire i_slow_clk, // slow internal oscillator, sampled as a pin
  input wire i_low_supply, // low supply indication from analog detector
  input wire i_clear_watchdog_instruction, // clear-watchdog instruction executed, pulse
  input wire i_halt, // halt instruction executed, pulse
  input wire i_wake, // core wakes from sleep or idle, pulse
  input wire i_psel, // apb select
  input wire i_penable, // apb enable
  input wire i_pwrite, // apb write
  input wire [11:0] i_paddr, // apb byte address
  input wire [31:0] i_pwdata, // apb write data
  output wire o_pready, // apb ready
  output reg [31:0] o_prdata, // apb read data
  output wire o_pslverr, // apb error on unmapped address
  output reg o_sys_reset, // full device reset request, pulse stretched
  output reg o_pc_sp_clear, // clear pc and stack pointer only, pulse
  output reg o_timeout, // timeout status bit
  output reg o_power_down, // power-down flag
  output wire o_low_power_mode // device is in sleep or idle
);
  localparam LV_CYCLES = (`WDR_LV_QUALIFY_NS + `WDR_CLK_PERIOD_NS - 1) / `WDR_CLK_PERIOD_NS;
  localparam ST_RUN = 2'b00;
  localparam ST_DELAY = 2'b01;
  localparam ST_RESET = 2'b10;

  reg [7:0] watchdog_control;
  reg soft_reset_flag;
  reg low_voltage_reset_flag;
  reg low_power;
  reg [`WDR_CNT_W-1:0] count;
  reg [1:0] state;
  reg [7:0] delay_cnt;
  reg [2:0] pulse_cnt;
  reg [15:0] lv_cnt;
  reg [31:0] next_prdata;
  reg [`WDR_CNT_W-1:0] limit;
  wire slow_tick;
  wire lv_level;
  wire [4:0] en_field;
  wire en_legal;
  wire overflow;
  wire wr_en;
  wire mapped;
  wire prog_reset;
  wire lv_fire;

  wdr_pulse_sync u_slow_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_async(i_slow_clk),
    .o_level(),
    .o_rise(slow_tick)
  );
  wdr_pulse_sync u_lv_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_async(i_low_supply),
    .o_level(lv_level),
    .o_rise()
  );

  assign en_field = watchdog_control[`WDR_EN_HI:`WDR_EN_LO];
  assign en_legal = (en_field == `WDR_EN_LEGAL_A) || (en_field == `WDR_EN_LEGAL_B); // RULE3
  assign o_low_power_mode = low_power;

  // timeout count per period select; compare is live so a new select acts at once
  always @* begin
    case (watchdog_control[`WDR_PS_HI:`WDR_PS_LO]) // RULE2
      3'h0: limit = `WDR_LIMIT_SEL0;
      3'h1: limit = `WDR_LIMIT_SEL1;
      3'h2: limit = `WDR_LIMIT_SEL2;
      3'h3: limit = `WDR_LIMIT_SEL3;
      3'h4: limit = `WDR_LIMIT_SEL4;
      3'h5: limit = `WDR_LIMIT_SEL5;
      3'h6: limit = `WDR_LIMIT_SEL6;
      default: limit = `WDR_LIMIT_SEL7;
    endcase
  end
  assign overflow = slow_tick && (count >= limit) && (state == ST_RUN); // RULE1 RULE23

  // apb: zero wait states, every access completes in its access cycle
  assign o_pready = 1'b1;
  assign mapped = (i_paddr == `WDR_ADDR_WDOG_CTRL) || (i_paddr == `WDR_ADDR_RST_FLAGS) ||
                  (i_paddr == `WDR_ADDR_PROG_CTRL) || (i_paddr == `WDR_ADDR_STATUS) ||
                  (i_paddr == `WDR_ADDR_CONTROL);
  assign o_pslverr = i_psel & i_penable & ~mapped;
  assign wr_en = i_ce & i_psel & i_penable & i_pwrite;
  assign prog_reset = wr_en && (i_paddr == `WDR_ADDR_PROG_CTRL) &&
                      (i_pwdata[7:0] == `WDR_PROG_RESET_KEY); // RULE18

  always @* begin
    next_prdata = 32'h0;
    case (i_paddr)
      `WDR_ADDR_WDOG_CTRL: next_prdata[7:0] = watchdog_control;
      `WDR_ADDR_RST_FLAGS: begin
        next_prdata[`WDR_BIT_SOFT_FLAG] = soft_reset_flag; // RULE17
        next_prdata[`WDR_BIT_LV_FLAG] = low_voltage_reset_flag;
      end
      `WDR_ADDR_STATUS: begin
        next_prdata[`WDR_BIT_TIMEOUT] = o_timeout;
        next_prdata[`WDR_BIT_PDOWN] = o_power_down;
        next_prdata[`WDR_BIT_LOWPWR] = low_power;
      end
      default: next_prdata = 32'h0;
    endcase
  end
  // read data registered during setup so it is stable in the access cycle
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prdata <= 32'h0;
    end else if (i_ce && i_psel && !i_penable) begin
      o_prdata <= next_prdata;
    end
  end

  // low-voltage qualification, disabled in sleep or idle
  assign lv_fire = lv_level && !low_power && (lv_cnt == LV_CYCLES[15:0] - 16'h1); // RULE14
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lv_cnt <= 16'h0;
    end else if (i_ce) begin
      if (!lv_level || low_power || state != ST_RUN) begin
        lv_cnt <= 16'h0; // RULE15
      end else if (!lv_fire) begin
        lv_cnt <= lv_cnt + 16'h1;
      end
    end
  end

  // control register and flags; a full reset restores control to its power-on value
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      watchdog_control <= `WDR_WDOG_CTRL_RESET; // RULE5
      soft_reset_flag <= 1'b0;
      low_voltage_reset_flag <= 1'b0;
      o_timeout <= 1'b0; // RULE21
      o_power_down <= 1'b0; // RULE20
      low_power <= 1'b0;
    end else if (i_ce) begin
      if (wr_en && i_paddr == `WDR_ADDR_WDOG_CTRL) begin
        watchdog_control <= i_pwdata[7:0]; // RULE6
      end else if (state == ST_RESET && pulse_cnt == 3'h0) begin
        watchdog_control <= `WDR_WDOG_CTRL_RESET;
      end
      // hardware set wins over a software clear in the same cycle
      if (state == ST_DELAY && delay_cnt == 8'h0) begin
        soft_reset_flag <= 1'b1; // RULE4 RULE7
      end else if (wr_en && i_paddr == `WDR_ADDR_RST_FLAGS && !i_pwdata[`WDR_BIT_SOFT_FLAG]) begin
        soft_reset_flag <= 1'b0; // RULE7
      end
      if (lv_fire) begin
        low_voltage_reset_flag <= 1'b1; // RULE16
      end else if (wr_en && i_paddr == `WDR_ADDR_RST_FLAGS && !i_pwdata[`WDR_BIT_LV_FLAG]) begin
        low_voltage_reset_flag <= 1'b0; // RULE16
      end
      if (overflow) begin
        o_timeout <= 1'b1; // RULE8 RULE9 RULE21
      end else if (i_halt) begin
        o_timeout <= 1'b0; // RULE19
      end
      if (i_halt) begin
        o_power_down <= 1'b1; // RULE19
      end else if (i_clear_watchdog_instruction) begin
        o_power_down <= 1'b0; // RULE20
      end
      if (i_halt) begin
        low_power <= 1'b1;
      end else if (i_wake || overflow) begin
        low_power <= 1'b0;
      end
    end
  end

  // counter free-runs in every mode; cleared by the three named sources and on overflow
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count <= {`WDR_CNT_W{1'b0}};
    end else if (i_ce) begin
      if (i_clear_watchdog_instruction || i_halt || (state == ST_DELAY && delay_cnt == 8'h0)) begin
        count <= {`WDR_CNT_W{1'b0}}; // RULE10 RULE19
      end else if (overflow) begin
        count <= {`WDR_CNT_W{1'b0}};
      end else if (slow_tick) begin
        count <= count + {{(`WDR_CNT_W-1){1'b0}}, 1'b1}; // RULE23
      end
    end
  end

  // reset sequencer: illegal enable waits soft delay, other sources reset at once
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_RUN;
      delay_cnt <= 8'h0;
      pulse_cnt <= 3'h0;
      o_sys_reset <= 1'b0;
      o_pc_sp_clear <= 1'b0;
    end else if (i_ce) begin
      o_pc_sp_clear <= 1'b0;
      case (state)
        ST_RUN: begin
          o_sys_reset <= 1'b0;
          if (prog_reset || lv_fire || (overflow && !low_power)) begin
            state <= ST_RESET; // RULE8 RULE14 RULE18
            pulse_cnt <= `WDR_RST_PULSE - 3'h1;
            o_sys_reset <= 1'b1;
          end else if (overflow) begin
            o_pc_sp_clear <= 1'b1; // RULE9
          end else if (!en_legal) begin
            state <= ST_DELAY; // RULE4
            // full SOFT_DELAY ticks elapse, then one cycle to enter reset
            delay_cnt <= SOFT_DELAY[7:0]; // RULE22
          end
        end
        ST_DELAY: begin
          if (delay_cnt == 8'h0) begin
            state <= ST_RESET;
            pulse_cnt <= `WDR_RST_PULSE - 3'h1;
            o_sys_reset <= 1'b1; // RULE4
          end else if (slow_tick) begin
            delay_cnt <= delay_cnt - 8'h1; // RULE22
          end
        end
        ST_RESET: begin
          // the core clears pc to zero and ports to all ones on this pulse
          o_sys_reset <= 1'b1; // RULE12 RULE13
          if (pulse_cnt == 3'h0) begin
            state <= ST_RUN;
            o_sys_reset <= 1'b0;
          end else begin
            pulse_cnt <= pulse_cnt - 3'h1;
          end
        end
        default: begin
          state <= ST_RUN;
          o_sys_reset <= 1'b0;
        end
      endcase
    end
  end
endmodule
